// ==== rtl/gpio_video_pkg.sv ====
// Register offsets, field positions and codes for the terminal and video port.
package gpio_video_pkg;

  // Configuration offsets of the three registers handled here.
  localparam logic [7:0] VIDEO_CTL_OFFSET = 8'h84;
  localparam logic [7:0] TERM0_CTL_OFFSET = 8'h88;
  localparam logic [7:0] TERM1_CTL_OFFSET = 8'h89;

  // Reset values.
  localparam logic [7:0] TERM_CTL_RESET  = 8'h80;
  localparam logic [7:0] VIDEO_CTL_RESET = 8'h00;

  // Video port control field positions.
  localparam int VID_OUT_EN_BIT = 7;
  localparam int VID_SEL_BIT    = 6;
  localparam int VID_EN1_BIT    = 1;
  localparam int VID_EN0_BIT    = 0;

  // Terminal control field positions.
  localparam int TERM_MODE_HI_BIT = 7;
  localparam int TERM_MODE_LO_BIT = 6;
  localparam int TERM_IRQ_EN_BIT  = 4;
  localparam int TERM_FLAG_BIT    = 3;
  localparam int TERM_DRIVE_BIT   = 1;
  localparam int TERM_SENSED_BIT  = 0;

  // Terminal function codes.
  localparam logic [1:0] MODE_ACTIVITY = 2'h0;
  localparam logic [1:0] MODE_VID_STAT = 2'h1;
  localparam logic [1:0] MODE_INPUT    = 2'h2;
  localparam logic [1:0] MODE_OUTPUT   = 2'h3;

  // Edges after reset release before a terminal change may be flagged.
  localparam int SENSE_PRIME_EDGES = 3;

endpackage

// ==== rtl/terminal_sense.sv ====
// Synchroniser and change detector for one general-purpose terminal.
`timescale 1ns/100ps
`default_nettype none

module terminal_sense (
  input  wire logic clk,           // Bus clock.
  input  wire logic arst_n,        // Asynchronous reset, active low.
  input  wire logic pin_level,     // Raw level on the terminal.
  output logic      sensed_level,  // Synchronised level.
  output logic      changed        // One-cycle pulse on a level change.
);

  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  last_reg;
  logic [gpio_video_pkg::SENSE_PRIME_EDGES-1:0] prime_reg;

  // Two-stage synchroniser; only the second stage and history are compared.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
      last_reg  <= 1'h0;
      prime_reg <= '0;
    end else begin
      sync1_reg <= pin_level;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      prime_reg <= {prime_reg[gpio_video_pkg::SENSE_PRIME_EDGES-2:0], 1'h1};
    end
  end

  // The history is only trusted once real samples fill it, so a terminal
  // held high through reset does not look like a change.
  assign sensed_level = sync2_reg;
  assign changed      = prime_reg[gpio_video_pkg::SENSE_PRIME_EDGES-1] &
                        (sync2_reg ^ last_reg);

endmodule
`default_nettype wire

// ==== rtl/gpio_video_ctrl.sv ====
// General-purpose terminal and video port control behind configuration space.
//
// Contract
// - Video output terminals float while output enable is 0, its reset value.
// - Select bit picks socket 0 or 1 video, only if that socket is enabled.
// - Video control bits 5 to 2 read zero and ignore writes.
// - Socket 1 video enable takes its video and stops its card drivers.
// - Socket 0 video enable takes its video and stops its card drivers.
// - Terminal 0 modes: activity, video status, input, output.
// - Terminal 1 modes: activity, reserved, input, output.
// - Both terminals reset to input mode with other bits clear.
// - Terminal 0 flag with its enable raises a socket A status change.
// - Terminal 1 flag with its enable raises a socket A status change.
// - Input-mode level change sets bit 3; writing 1 clears it.
// - Output mode drives the last value written to bit 1.
// - Bit 0 reads the present terminal level in input and output modes.
// - Terminal control bits 5 and 2 read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module gpio_video_ctrl #(
  parameter int VIDEO_W = 8        // Width of the video data path.
) (
  input  wire logic               clk,               // Bus clock, 25 MHz.
  input  wire logic               arst_n,            // Reset, active low.
  input  wire logic               cfg_wr,            // Config write strobe.
  input  wire logic               cfg_rd,            // Config read strobe.
  input  wire logic [7:0]         cfg_addr,          // Config byte offset.
  input  wire logic [7:0]         cfg_wdata,         // Config write data.
  output logic      [7:0]         cfg_rdata,         // Read data, registered.
  input  wire logic               socket0_activity,  // Socket 0 busy.
  input  wire logic               socket1_activity,  // Socket 1 busy.
  input  wire logic               term0_in,          // Terminal 0 level.
  output logic                    term0_out,         // Terminal 0 drive.
  output logic                    term0_oe,          // Terminal 0 enable.
  input  wire logic               term1_in,          // Terminal 1 level.
  output logic                    term1_out,         // Terminal 1 drive.
  output logic                    term1_oe,          // Terminal 1 enable.
  output logic                    card_status_change_event, // Socket A.
  input  wire logic [VIDEO_W-1:0] socket0_video_in,  // Socket 0 video.
  input  wire logic [VIDEO_W-1:0] socket1_video_in,  // Socket 1 video.
  output logic                    socket0_video_accept, // Socket 0 taken.
  output logic                    socket1_video_accept, // Socket 1 taken.
  output logic                    socket0_card_drive_en, // Socket 0 pins.
  output logic                    socket1_card_drive_en, // Socket 1 pins.
  output logic      [VIDEO_W-1:0] video_out,         // Outgoing video.
  output logic                    video_out_oe       // Outgoing enable.
);

  // Video port control state.
  logic               video_out_drive_enable_reg;
  logic               video_source_select_reg;
  logic               socket1_video_mode_enable_reg;
  logic               socket0_video_mode_enable_reg;
  logic [VIDEO_W-1:0] video_out_reg;
  logic [VIDEO_W-1:0] video_out_next;

  // Terminal control state, index 0 and 1.
  logic [1:0] mode_reg   [2];
  logic [1:0] irq_en_reg;
  logic [1:0] flag_reg;
  logic [1:0] drive_reg;
  logic [1:0] flag_next;
  logic [7:0] cfg_rdata_reg;
  logic [7:0] rd_mux;

  // Synchronised terminal levels and change pulses.
  logic [1:0] sensed;
  logic [1:0] changed;
  logic [1:0] in_input_mode;
  logic [1:0] term_wr;
  logic [1:0] term_pin_out;
  logic [1:0] term_pin_oe;
  logic       video_wr;

  // Packs one terminal's fields into its control byte.
  function automatic logic [7:0] term_pack(input logic [1:0] mode,
                                           input logic       irq_en,
                                           input logic       flag,
                                           input logic       drive,
                                           input logic       level);
    logic [7:0] v;
    v = 8'h00;
    v[gpio_video_pkg::TERM_MODE_HI_BIT:gpio_video_pkg::TERM_MODE_LO_BIT] =
      mode;
    v[gpio_video_pkg::TERM_IRQ_EN_BIT] = irq_en;
    v[gpio_video_pkg::TERM_FLAG_BIT]   = flag;
    v[gpio_video_pkg::TERM_DRIVE_BIT]  = drive;
    v[gpio_video_pkg::TERM_SENSED_BIT] = level;
    return v;
  endfunction

  terminal_sense u_sense0 (
    .clk          (clk),
    .arst_n       (arst_n),
    .pin_level    (term0_in),
    .sensed_level (sensed[0]),
    .changed      (changed[0])
  );

  terminal_sense u_sense1 (
    .clk          (clk),
    .arst_n       (arst_n),
    .pin_level    (term1_in),
    .sensed_level (sensed[1]),
    .changed      (changed[1])
  );

  // Address decode; both functions see the same registers.
  assign video_wr   = cfg_wr && (cfg_addr == gpio_video_pkg::VIDEO_CTL_OFFSET);
  assign term_wr[0] = cfg_wr && (cfg_addr == gpio_video_pkg::TERM0_CTL_OFFSET);
  assign term_wr[1] = cfg_wr && (cfg_addr == gpio_video_pkg::TERM1_CTL_OFFSET);

  // Change flags: a new change wins over a write-one clear in the same cycle.
  assign in_input_mode[0] = (mode_reg[0] == gpio_video_pkg::MODE_INPUT);
  assign in_input_mode[1] = (mode_reg[1] == gpio_video_pkg::MODE_INPUT);
  assign flag_next[0] = (changed[0] & in_input_mode[0]) |
                        (flag_reg[0] & ~(term_wr[0] &
                         cfg_wdata[gpio_video_pkg::TERM_FLAG_BIT]));
  assign flag_next[1] = (changed[1] & in_input_mode[1]) |
                        (flag_reg[1] & ~(term_wr[1] &
                         cfg_wdata[gpio_video_pkg::TERM_FLAG_BIT]));

  // Terminal control registers; bits 5 and 2 have no storage at all.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2; i++) begin
        mode_reg[i] <= gpio_video_pkg::TERM_CTL_RESET[7:6];
      end
      irq_en_reg <= 2'h0;
      flag_reg   <= 2'h0;
      drive_reg  <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (term_wr[i]) begin
          mode_reg[i]   <= cfg_wdata[7:6];
          irq_en_reg[i] <= cfg_wdata[gpio_video_pkg::TERM_IRQ_EN_BIT];
          drive_reg[i]  <= cfg_wdata[gpio_video_pkg::TERM_DRIVE_BIT];
        end
      end
      flag_reg <= flag_next;
    end
  end

  // Video port control register; bits 5 to 2 are not stored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      video_out_drive_enable_reg    <= 1'h0;
      video_source_select_reg       <= 1'h0;
      socket1_video_mode_enable_reg <= 1'h0;
      socket0_video_mode_enable_reg <= 1'h0;
    end else if (video_wr) begin
      video_out_drive_enable_reg <=
        cfg_wdata[gpio_video_pkg::VID_OUT_EN_BIT];
      video_source_select_reg <= cfg_wdata[gpio_video_pkg::VID_SEL_BIT];
      socket1_video_mode_enable_reg <=
        cfg_wdata[gpio_video_pkg::VID_EN1_BIT];
      socket0_video_mode_enable_reg <=
        cfg_wdata[gpio_video_pkg::VID_EN0_BIT];
    end
  end

  // Video source: a socket whose video mode is off contributes zeros.
  assign video_out_next =
    video_source_select_reg ?
      (socket1_video_mode_enable_reg ? socket1_video_in : '0) :
      (socket0_video_mode_enable_reg ? socket0_video_in : '0);

  // The video path is registered to keep the outgoing port glitch free.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      video_out_reg <= '0;
    end else begin
      video_out_reg <= video_out_next;
    end
  end

  assign video_out    = video_out_reg;
  assign video_out_oe = video_out_drive_enable_reg;

  // Enabled sockets feed video in, so their card-side drivers must let go.
  assign socket1_video_accept  = socket1_video_mode_enable_reg;
  assign socket1_card_drive_en = ~socket1_video_mode_enable_reg;
  assign socket0_video_accept  = socket0_video_mode_enable_reg;
  assign socket0_card_drive_en = ~socket0_video_mode_enable_reg;

  // Terminal 0 function; video status follows the output enable bit.
  assign term_pin_out[0] =
    (mode_reg[0] == gpio_video_pkg::MODE_ACTIVITY) ? socket0_activity :
    (mode_reg[0] == gpio_video_pkg::MODE_VID_STAT) ?
      video_out_drive_enable_reg : drive_reg[0];
  assign term_pin_oe[0] = ~in_input_mode[0];

  // Terminal 1 does not drive under the reserved code, but flags changes only in input mode.
  assign term_pin_out[1] =
    (mode_reg[1] == gpio_video_pkg::MODE_ACTIVITY) ? socket1_activity :
    drive_reg[1];
  assign term_pin_oe[1] = (mode_reg[1] == gpio_video_pkg::MODE_ACTIVITY) |
                          (mode_reg[1] == gpio_video_pkg::MODE_OUTPUT);

  assign term0_out = term_pin_out[0];
  assign term0_oe  = term_pin_oe[0];
  assign term1_out = term_pin_out[1];
  assign term1_oe  = term_pin_oe[1];

  // Both terminals raise the same socket A status change line.
  assign card_status_change_event = (flag_reg[0] & irq_en_reg[0]) |
                                    (flag_reg[1] & irq_en_reg[1]);

  // Read mux; reserved bits come from constant zeros.
  assign rd_mux =
    (cfg_addr == gpio_video_pkg::VIDEO_CTL_OFFSET) ?
      {video_out_drive_enable_reg, video_source_select_reg, 4'h0,
       socket1_video_mode_enable_reg,
       socket0_video_mode_enable_reg} :
    (cfg_addr == gpio_video_pkg::TERM0_CTL_OFFSET) ?
      term_pack(mode_reg[0], irq_en_reg[0], flag_reg[0], drive_reg[0],
                sensed[0]) :
    (cfg_addr == gpio_video_pkg::TERM1_CTL_OFFSET) ?
      term_pack(mode_reg[1], irq_en_reg[1], flag_reg[1], drive_reg[1],
                sensed[1]) :
    8'h00;

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata_reg <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata_reg <= rd_mux;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_video_oe_write: assert property (
    video_wr |=> video_out_oe == $past(cfg_wdata[7]))
    else $error("video output enable does not follow write");

  a_video_source_pick: assert property (
    (!video_source_select_reg && socket0_video_mode_enable_reg)
      |=> video_out == $past(socket0_video_in))
    else $error("socket 0 video not forwarded");

  a_video_source_off: assert property (
    (video_source_select_reg && !socket1_video_mode_enable_reg)
      |=> video_out == '0)
    else $error("disabled socket 1 video forwarded");

  a_video_resv_zero: assert property (
    (cfg_rd && cfg_addr == gpio_video_pkg::VIDEO_CTL_OFFSET)
      |=> cfg_rdata[5:2] == 4'h0)
    else $error("video reserved bits not zero");

  a_sock1_drive_off: assert property (
    (video_wr && cfg_wdata[1]) |=> !socket1_card_drive_en &&
      socket1_video_accept)
    else $error("socket 1 drivers left on");

  a_sock0_drive_off: assert property (
    (video_wr && cfg_wdata[0]) |=> !socket0_card_drive_en)
    else $error("socket 0 drivers left on");

  a_term_vid_stat: assert property (
    (mode_reg[0] == gpio_video_pkg::MODE_VID_STAT)
      |-> term0_oe && term0_out == video_out_oe)
    else $error("video status not shown on terminal 0");

  a_term_input_float: assert property (
    in_input_mode[1] |-> !term1_oe && !term0_oe || !in_input_mode[0])
    else $error("input terminal driven");

  a_term_out_drive: assert property (
    (term_wr[0] && cfg_wdata[7:6] == gpio_video_pkg::MODE_OUTPUT)
      |=> term0_oe && term0_out == $past(cfg_wdata[1]))
    else $error("output mode drives wrong value");

  a_flag_set_wins: assert property (
    (changed[0] && in_input_mode[0]) |=> flag_reg[0])
    else $error("change flag missed");

  a_flag_clear: assert property (
    (term_wr[1] && cfg_wdata[3] && !(changed[1] && in_input_mode[1]))
      |=> !flag_reg[1])
    else $error("change flag not cleared");

  a_irq_raise: assert property (
    (changed[0] && in_input_mode[0] && irq_en_reg[0] && !term_wr[0])
      |=> card_status_change_event)
    else $error("status change not raised for terminal 0");

  a_irq_raise1: assert property (
    (changed[1] && in_input_mode[1] && irq_en_reg[1] && !term_wr[1])
      |=> card_status_change_event)
    else $error("status change not raised for terminal 1");

  a_term_readback: assert property (
    (cfg_rd && cfg_addr == gpio_video_pkg::TERM0_CTL_OFFSET)
      |=> cfg_rdata[0] == $past(sensed[0]) && cfg_rdata[5] == 1'h0 &&
          cfg_rdata[2] == 1'h0)
    else $error("terminal 0 readback wrong");

  c_flag_irq: cover property (changed[0] && irq_en_reg[0] ##1
                              card_status_change_event);
  c_video_sock1: cover property (video_out_oe && video_source_select_reg &&
                                 socket1_video_mode_enable_reg);
  c_term_output: cover property (mode_reg[1] ==
                                 gpio_video_pkg::MODE_OUTPUT && term1_out);
  c_flag_clear: cover property (flag_reg[0] ##1 !flag_reg[0]);

endmodule
`default_nettype wire

// ==== verif/socket_side_model.sv ====
// Far-side model: socket video sources and the two terminal wires.
`timescale 1ns/100ps
`default_nettype none

module socket_side_model #(
  parameter logic [7:0] SOCK0_WORD = 8'hA5,  // Socket 0 video word.
  parameter logic [7:0] SOCK1_WORD = 8'h3C   // Socket 1 video word.
) (
  input  wire logic       ext0_level,  // Outside source, terminal 0.
  input  wire logic       ext1_level,  // Outside source, terminal 1.
  input  wire logic       term0_out,   // Device drive, terminal 0.
  input  wire logic       term0_oe,    // Device enable, terminal 0.
  input  wire logic       term1_out,   // Device drive, terminal 1.
  input  wire logic       term1_oe,    // Device enable, terminal 1.
  input  wire logic       accept0,     // Socket 0 in video mode.
  input  wire logic       accept1,     // Socket 1 in video mode.
  output logic            term0_wire,  // Resolved level, terminal 0.
  output logic            term1_wire,  // Resolved level, terminal 1.
  output logic      [7:0] sock0_video, // Socket 0 video lines.
  output logic      [7:0] sock1_video  // Socket 1 video lines.
);
  // The outside source is weak, so the device driver wins while enabled.
  assign term0_wire = term0_oe ? term0_out : ext0_level;
  assign term1_wire = term1_oe ? term1_out : ext1_level;
  // A card not in video mode shows junk, so a wrong pick is visible.
  assign sock0_video = accept0 ? SOCK0_WORD : ~SOCK0_WORD;
  assign sock1_video = accept1 ? SOCK1_WORD : ~SOCK1_WORD;
endmodule
`default_nettype wire

// ==== verif/test_gpio_video_ctrl.sv ====
// Self-checking bench for the terminal and video port control block.
`timescale 1ns/100ps
`default_nettype none

module test_gpio_video_ctrl;
  logic       clk, arst_n, cfg_wr, cfg_rd, act0, act1, ext0, ext1;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v0, v1, vout;
  logic       pin0, pin1, out0, oe0, out1, oe1, evt;
  logic       acc0, acc1, den0, den1, vid_oe;
  int         bad_count, compares, cycles;

  gpio_video_ctrl dut (
    .clk(clk), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .socket0_activity(act0), .socket1_activity(act1),
    .term0_in(pin0), .term0_out(out0), .term0_oe(oe0),
    .term1_in(pin1), .term1_out(out1), .term1_oe(oe1),
    .card_status_change_event(evt),
    .socket0_video_in(v0), .socket1_video_in(v1),
    .socket0_video_accept(acc0), .socket1_video_accept(acc1),
    .socket0_card_drive_en(den0), .socket1_card_drive_en(den1),
    .video_out(vout), .video_out_oe(vid_oe));

  socket_side_model model (
    .ext0_level(ext0), .ext1_level(ext1), .term0_out(out0),
    .term0_oe(oe0), .term1_out(out1), .term1_oe(oe1), .accept0(acc0),
    .accept1(acc1), .term0_wire(pin0), .term1_wire(pin1),
    .sock0_video(v0), .sock1_video(v1));

  // The ceiling is far above the roughly 140 cycles the tests need.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      $display("MISMATCH at %0t: run timed out", $time);
      end_of_test();
    end
  end

  // Comparison helpers; bytes hold single flags packed low.
  task chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask

  // All register traffic goes through function 0 only.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'h1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'h0;
    #1;
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] exp, input string w);
    @(posedge clk);
    cfg_rd <= 1'h1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'h0;
    #1;
    chk(cfg_rdata, exp, w);
  endtask

  // Pin and activity changes land on a rising edge like any other input.
  task drive(input logic a0, input logic a1, input logic e0,
             input logic e1);
    @(posedge clk);
    act0 <= a0;
    act1 <= a1;
    ext0 <= e0;
    ext1 <= e1;
    #1;
  endtask

  // Enough edges for the synchroniser, the flag and the video register.
  task settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task t_reset;
    rdchk(8'h88, 8'h80, "term0 reset");
    rdchk(8'h89, 8'h80, "term1 reset");
    rdchk(8'h84, 8'h00, "video reset");
    chk({4'h0, oe1, oe0, vid_oe, evt}, 8'h00, "idle drives");
    chk({6'h00, den1, den0}, 8'h03, "card drivers");
    $display("test reset finished");
  endtask

  task t_video;
    wr(8'h84, 8'hFF);
    rdchk(8'h84, 8'hC3, "video reserved bits");
    chk({5'h00, vid_oe, acc1, acc0}, 8'h07, "video on");
    chk({6'h00, den1, den0}, 8'h00, "both drivers off");
    wr(8'h84, 8'h81);
    settle();
    chk(vout, 8'hA5, "socket 0 picked");
    chk({6'h00, den1, den0}, 8'h02, "socket 0 driver");
    wr(8'h84, 8'hC2);
    settle();
    chk(vout, 8'h3C, "socket 1 picked");
    chk({6'h00, den1, den0}, 8'h01, "socket 1 driver");
    wr(8'h84, 8'hC1);
    settle();
    chk(vout, 8'h00, "disabled socket");
    wr(8'h84, 8'h41);
    chk({7'h00, vid_oe}, 8'h00, "video floats");
    $display("test video finished");
  endtask

  task t_modes;
    wr(8'h84, 8'h80);
    wr(8'h88, 8'h40);
    wr(8'h89, 8'h40);
    chk({4'h0, oe1, out1, oe0, out0}, 8'h03, "status on");
    wr(8'h84, 8'h00);
    chk({6'h00, oe0, out0}, 8'h02, "status off");
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h00);
    drive(1'h1, 1'h1, 1'h0, 1'h0);
    chk({4'h0, oe1, out1, oe0, out0}, 8'h0F, "both busy");
    drive(1'h0, 1'h1, 1'h0, 1'h0);
    chk({4'h0, oe1, out1, oe0, out0}, 8'h0E, "socket 1 busy");
    drive(1'h0, 1'h0, 1'h0, 1'h0);
    wr(8'h88, 8'h80);
    wr(8'h89, 8'h80);
    chk({6'h00, oe1, oe0}, 8'h00, "inputs float");
    $display("test modes finished");
  endtask

  // Both terminals go back low while still in output mode, and the
  // settle lets that edge pass before input mode could flag it.
  task t_out;
    wr(8'h88, 8'hE6);
    wr(8'h89, 8'hC2);
    chk({4'h0, oe1, out1, oe0, out0}, 8'h0F, "drive high");
    settle();
    rdchk(8'h88, 8'hC3, "output readback");
    rdchk(8'h89, 8'hC3, "term1 readback");
    wr(8'h88, 8'hC0);
    wr(8'h89, 8'hC0);
    settle();
    rdchk(8'h88, 8'hC0, "no flag in output");
    rdchk(8'h89, 8'hC0, "term1 no flag");
    wr(8'h88, 8'h80);
    wr(8'h89, 8'h80);
    $display("test output finished");
  endtask

  task t_irq;
    wr(8'h88, 8'h90);
    wr(8'h89, 8'h90);
    drive(1'h0, 1'h0, 1'h1, 1'h0);
    settle();
    rdchk(8'h88, 8'h99, "term0 flag");
    chk({7'h00, evt}, 8'h01, "term0 event");
    wr(8'h88, 8'h98);
    settle();
    rdchk(8'h88, 8'h91, "term0 cleared");
    chk({7'h00, evt}, 8'h00, "event gone");
    drive(1'h0, 1'h0, 1'h1, 1'h1);
    settle();
    rdchk(8'h89, 8'h99, "term1 flag");
    chk({7'h00, evt}, 8'h01, "term1 event");
    wr(8'h89, 8'h88);
    drive(1'h0, 1'h0, 1'h1, 1'h0);
    settle();
    rdchk(8'h89, 8'h88, "masked flag");
    chk({7'h00, evt}, 8'h00, "masked event");
    $display("test change events finished");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset for two edges, then let change detection prime before tests.
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    {cfg_wr, cfg_rd, act0, act1, ext0, ext1} = 6'h00;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset();
    t_video();
    t_modes();
    t_out();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
